// [verilog/sar_conv_map.svh]
// constants, timing figures and codes of the converter control block
// Contract
// - busy high exactly while converting
// - convert request honoured only while selected
// - frame sync ignored while deselected
// - shift on rising clock, only when selected
// - msb at frame start, later bits on rises
// - powerdown request resets logic, full power-down
// - conversion begins promptly after qualified start
// - abort drops busy promptly
// - frame sync high at busy fall reloads msb
// - host waits resume time after nap/power-down
// - untrimmed circuitry needs 1 ms resume
// - nap entry 200 ns, power-down 10 us
// - qualified request falling edge starts conversion
// - aborted conversion yields fixed code, wait state (the code goes to wait only when the buffer is not full at the abort)
// - second bit after first falling edge
`ifndef SAR_CONV_MAP_SVH
`define SAR_CONV_MAP_SVH
`define CLK_PERIOD_NS 25
`define T_CONV_NS 1000
`define T_START_MAX_NS 10
`define T_ABORT_MAX_NS 10
`define T_NAP_ENTER_NS 200
`define T_FULL_PD_ENTER_NS 10000
`define T_NAP_RESUME_NS 300
`define T_UNTRIM_RESUME_NS 1000000
`define T_INTREF_RESUME_NS 25000000
`define RESULT_BITS 18
`define ABORT_CODE 18'h3FC00
`define BUF_DEPTH 2
`endif

// [verilog/sar_conv_pkg.sv]
// types shared by the converter control block
package sar_conv_pkg;
  // host-facing pins, carried together through the synchroniser
  typedef struct packed {
    logic conv;
    logic cs_n;
    logic fs;
    logic sclk;
    logic pd;
  } pins_s;
  // converter phases, one-hot
  typedef enum logic [5:0] {
    ST_RESUME = 6'h01,
    ST_SAMPLE = 6'h02,
    ST_CONVERT = 6'h04,
    ST_WAIT = 6'h08,
    ST_NAP = 6'h10,
    ST_STALL = 6'h20
  } conv_state_e;
endpackage

// [verilog/sar_conv_ctrl.sv]
// conversion control, power-down and serial readout of the sar converter
`timescale 1ns/100ps
`default_nettype none
`include "sar_conv_map.svh"
module sar_conv_ctrl #(
  parameter int WIDTH = `RESULT_BITS,
  parameter int DEPTH = `BUF_DEPTH,
  parameter int UNTRIM_CYC = `T_UNTRIM_RESUME_NS / `CLK_PERIOD_NS,
  parameter int INTREF_CYC = `T_INTREF_RESUME_NS / `CLK_PERIOD_NS
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic convert_request,
  input wire logic chip_select_n,
  input wire logic frame_sync_in,
  input wire logic shift_clk,
  input wire logic powerdown_request,
  input wire logic internal_ref_used,
  input wire logic [WIDTH-1:0] conv_code,
  output logic busy,
  output logic serial_result_out,
  output logic serial_out_en,
  output logic nap_active,
  output logic full_powerdown,
  output logic resume_done
);
  // ----------------------------------------------------------------
  // cycle counts and checks
  // ----------------------------------------------------------------
  localparam int CONV_CYC = (`T_CONV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int NAPE_CYC = `T_NAP_ENTER_NS / `CLK_PERIOD_NS;
  localparam int PDE_CYC = `T_FULL_PD_ENTER_NS / `CLK_PERIOD_NS;
  localparam int NAPR_CYC = `T_NAP_RESUME_NS / `CLK_PERIOD_NS;
  localparam int CW = 32;
  localparam int AW = $clog2(DEPTH);
  initial begin
    // the nap resume preloads the timer, so the untrimmed count must cover it
    if (WIDTH < 2 || DEPTH != 2 ** AW || DEPTH < 2 || UNTRIM_CYC < 1 || INTREF_CYC < 1
        || UNTRIM_CYC < NAPR_CYC)
      $error("unsupported parameter values");
  end

  // ----------------------------------------------------------------
  // pin synchroniser: stage one feeds stage two only
  // ----------------------------------------------------------------
  sar_conv_pkg::pins_s pin_raw;
  sar_conv_pkg::pins_s s1_q, s2_q, s3_q; // s3 is only the edge history
  assign pin_raw = '{conv: convert_request, cs_n: chip_select_n, fs: frame_sync_in,
                     sclk: shift_clk, pd: powerdown_request};
  // the three stages only register, no logic between them
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s1_q <= '{conv: 1'b1, cs_n: 1'b1, fs: 1'b0, sclk: 1'b0, pd: 1'b0};
      s2_q <= '{conv: 1'b1, cs_n: 1'b1, fs: 1'b0, sclk: 1'b0, pd: 1'b0};
      s3_q <= '{conv: 1'b1, cs_n: 1'b1, fs: 1'b0, sclk: 1'b0, pd: 1'b0};
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // powerdown request acts as a second reset of all working state except the synchroniser and the power-down timer
  logic rst;
  assign rst = !resetn || s2_q.pd;

  // ----------------------------------------------------------------
  // qualified convert request and edges
  // ----------------------------------------------------------------
  logic qconv_q, qconv_d; // request latched while selected
  always_comb begin
    qconv_d = qconv_q;
    if (!s2_q.cs_n)
      qconv_d = s2_q.conv;
  end
  logic qconv_fall, sclk_rise, sclk_fall, frame_start;
  assign qconv_fall = qconv_q && !qconv_d;
  assign sclk_rise = s2_q.sclk && !s3_q.sclk && !s2_q.cs_n;
  assign sclk_fall = !s2_q.sclk && s3_q.sclk && !s2_q.cs_n;
  // cs fall with fs high, or fs rise while selected, opens a frame
  assign frame_start = (s2_q.fs && !s2_q.cs_n)
                       && (s3_q.cs_n || !s3_q.fs);

  // ----------------------------------------------------------------
  // two-entry result buffer between conversion and readout
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] buf_mem_q [DEPTH];
  logic [WIDTH-1:0] buf_mem_d [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [AW:0] fill_q, fill_d;
  logic in_valid, in_ready, out_valid, out_ready;
  logic [WIDTH-1:0] in_data;
  assign in_ready = fill_q != DEPTH[AW:0];
  assign out_valid = fill_q != '0;
  // pointer and fill arithmetic
  always_comb begin
    buf_mem_d = buf_mem_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    fill_d = fill_q;
    if (in_valid && in_ready) begin
      buf_mem_d[wr_ptr_q] = in_data;
      wr_ptr_d = wr_ptr_q + 1'b1;
    end
    if (out_valid && out_ready)
      rd_ptr_d = rd_ptr_q + 1'b1;
    fill_d = fill_q + {{AW{1'b0}}, in_valid && in_ready}
                    - {{AW{1'b0}}, out_valid && out_ready};
  end

  // ----------------------------------------------------------------
  // conversion state machine
  // ----------------------------------------------------------------
  sar_conv_pkg::conv_state_e st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d; // conversion, nap and resume timer
  logic [CW-1:0] pd_cnt_q, pd_cnt_d; // power-down entry timer
  logic busy_q, busy_d, nap_q, nap_d, fpd_q, fpd_d, rdy_q, rdy_d;
  logic [WIDTH-1:0] pend_q, pend_d; // word waiting for buffer room
  logic sample_cmd;
  assign sample_cmd = s2_q.conv && !s2_q.cs_n;
  // next phase; in_valid is the write into the buffer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 1'b1;
    pend_d = pend_q;
    in_valid = 1'b0;
    in_data = pend_q;
    nap_d = 1'b0;
    rdy_d = rdy_q;
    case (st_q)
      sar_conv_pkg::ST_RESUME: begin
        // untrimmed circuitry first, then the reference if internal
        if (cnt_q >= CW'(UNTRIM_CYC) + (internal_ref_used ? CW'(INTREF_CYC) : '0)) begin
          rdy_d = 1'b1;
          st_d = sar_conv_pkg::ST_WAIT;
        end
      end
      sar_conv_pkg::ST_SAMPLE: begin
        if (qconv_fall) begin
          st_d = sar_conv_pkg::ST_CONVERT;
          cnt_d = '0;
        end
      end
      sar_conv_pkg::ST_CONVERT: begin
        if (qconv_fall) begin
          // a second start aborts: fixed code, then wait if the buffer is not full
          pend_d = `ABORT_CODE;
          st_d = sar_conv_pkg::ST_STALL;
          cnt_d = '1;
        end else if (cnt_q == CW'(CONV_CYC - 1)) begin
          pend_d = conv_code;
          st_d = sar_conv_pkg::ST_STALL;
          cnt_d = '0;
        end
      end
      sar_conv_pkg::ST_STALL: begin
        // buffer write; a full buffer stalls here with busy low
        in_valid = 1'b1;
        if (in_ready) begin
          cnt_d = '0;
          if (cnt_q == '1)
            st_d = sar_conv_pkg::ST_WAIT;
          else if (sample_cmd)
            st_d = sar_conv_pkg::ST_SAMPLE;
          else if (!qconv_q)
            st_d = sar_conv_pkg::ST_NAP;
          else
            st_d = sar_conv_pkg::ST_WAIT;
        end
      end
      sar_conv_pkg::ST_WAIT: begin
        if (sample_cmd && rdy_q)
          st_d = sar_conv_pkg::ST_SAMPLE;
      end
      sar_conv_pkg::ST_NAP: begin
        // low-power flag after entry time, leaving waits out resume
        nap_d = cnt_q >= CW'(NAPE_CYC - 1);
        if (sample_cmd) begin
          st_d = sar_conv_pkg::ST_RESUME;
          // external reference: only the nap resume remains of the untrimmed count
          cnt_d = CW'(UNTRIM_CYC) - CW'(NAPR_CYC);
          rdy_d = 1'b0;
        end
      end
      default: st_d = sar_conv_pkg::ST_WAIT;
    endcase
    if (internal_ref_used && st_q == sar_conv_pkg::ST_NAP && sample_cmd)
      cnt_d = CW'(UNTRIM_CYC) + CW'(INTREF_CYC) - CW'(NAPR_CYC);
    busy_d = st_d == sar_conv_pkg::ST_CONVERT;
    // power-down flag counts while the request holds reset
    if (!s2_q.pd) begin
      pd_cnt_d = '0;
      fpd_d = 1'b0;
    end else begin
      // saturate so a long request never wraps the flag off
      pd_cnt_d = (pd_cnt_q == CW'(PDE_CYC)) ? pd_cnt_q : pd_cnt_q + 1'b1;
      fpd_d = pd_cnt_q >= CW'(PDE_CYC - 1);
    end
  end

  // ----------------------------------------------------------------
  // readout shifter
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] sh_q, sh_d;
  logic fell_q, fell_d, sdo_q, sdo_d, oe_q, oe_d, bfall_q, bfall_d, load;
  // fires when the fresh word has landed in the buffer, one cycle after busy falls,
  // so the reload pops the new result and not an empty buffer
  assign bfall_d = in_valid && in_ready;
  assign load = frame_start || (bfall_q && s2_q.fs && !s2_q.cs_n);
  assign out_ready = load;
  // frame load, fall seen, then one bit per rising edge
  always_comb begin
    sh_d = sh_q;
    fell_d = fell_q;
    if (load) begin
      if (out_valid)
        sh_d = buf_mem_q[rd_ptr_q];
      fell_d = 1'b0;
    end else if (sclk_fall) begin
      fell_d = 1'b1;
    end else if (sclk_rise && fell_q) begin
      sh_d = {sh_q[WIDTH-2:0], 1'b0};
    end
    sdo_d = sh_d[WIDTH-1];
    oe_d = !s2_q.cs_n;
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= sar_conv_pkg::ST_RESUME;
      cnt_q <= '0;
      busy_q <= 1'b0;
      nap_q <= 1'b0;
      rdy_q <= 1'b0;
      pend_q <= '0;
      qconv_q <= 1'b1;
      buf_mem_q <= '{default: '0};
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q <= '0;
      sh_q <= '0;
      fell_q <= 1'b0;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      bfall_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      nap_q <= nap_d;
      rdy_q <= rdy_d;
      pend_q <= pend_d;
      qconv_q <= qconv_d;
      buf_mem_q <= buf_mem_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      fill_q <= fill_d;
      sh_q <= sh_d;
      fell_q <= fell_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
      bfall_q <= bfall_d;
    end
  end
  // the power-down timer runs only while the request is held
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pd_cnt_q <= '0;
      fpd_q <= 1'b0;
    end else begin
      pd_cnt_q <= pd_cnt_d;
      fpd_q <= fpd_d;
    end
  end
  assign busy = busy_q;
  assign serial_result_out = sdo_q;
  assign serial_out_en = oe_q;
  assign nap_active = nap_q;
  assign full_powerdown = fpd_q;
  assign resume_done = rdy_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_busy_conv;
    st_q == sar_conv_pkg::ST_CONVERT |-> busy_q;
  endproperty
  a_busy_conv: assert property (p_busy_conv) else $error("busy low in conversion");
  property p_cs_gate;
    s2_q.cs_n && $past(s2_q.cs_n) |-> $stable(qconv_q);
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("request used while deselected");
  property p_start;
    st_q == sar_conv_pkg::ST_SAMPLE && qconv_fall |=> busy_q ##[1:2] busy_q;
  endproperty
  a_start: assert property (p_start) else $error("conversion did not start");
  property p_abort;
    st_q == sar_conv_pkg::ST_CONVERT && qconv_fall |=> !busy_q && pend_q == `ABORT_CODE;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not handled");
  property p_conv_len;
    $rose(busy_q) |-> busy_q [*8];
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion too short");
  property p_noshift;
    s2_q.cs_n && !load |=> $stable(sh_q);
  endproperty
  a_noshift: assert property (p_noshift) else $error("shift while deselected");
  property p_msb;
    load && out_valid |=> sdo_q == $past(buf_mem_q[rd_ptr_q][WIDTH-1]);
  endproperty
  a_msb: assert property (p_msb) else $error("msb not presented");
  property p_reload;
    bfall_q && s2_q.fs && !s2_q.cs_n |-> load;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at busy fall");
  property p_second;
    load ##1 (!sclk_fall && !load) [*2] |=> $stable(sh_q) || load;
  endproperty
  a_second: assert property (p_second) else $error("shift before first fall");
  c_back: cover property ($fell(busy_q) ##[1:4] st_q == sar_conv_pkg::ST_SAMPLE);
  c_abort: cover property (st_q == sar_conv_pkg::ST_CONVERT && qconv_fall);
  c_nap: cover property ($rose(nap_q));
  c_full: cover property (!in_ready ##1 load);
endmodule // sar_conv_ctrl
`default_nettype wire

// [dv/host_model.sv]
// host controller model driving the conversion and readout pins
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic clk_sys,
  input wire logic serial_result_out,
  output logic convert_request,
  output logic chip_select_n,
  output logic frame_sync_in,
  output logic shift_clk,
  output logic powerdown_request
);
  // ----------------------------------------
  // idle levels at time zero
  // ----------------------------------------
  initial begin
    convert_request = 1'b0;
    chip_select_n = 1'b1;
    frame_sync_in = 1'b1; // select-framed readout keeps frame sync high
    shift_clk = 1'b1; // idles high so a frame opens with a fall, stands still between frames
    powerdown_request = 1'b0;
  end
  // ----------------------------------------
  // pin sequences
  // ----------------------------------------
  // n clock edges, then the fixed drive delay
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // sample phase long enough to cover a nap resume, then the start edge
  task automatic start_conv();
    chip_select_n = 1'b0;
    convert_request = 1'b1;
    cyc(20); // nap resume allowed before relying on sampling
    convert_request = 1'b0;
  endtask
  // a second qualified falling edge while converting
  task automatic abort_conv();
    convert_request = 1'b1;
    cyc(4);
    convert_request = 1'b0;
  endtask
  // one select-framed read; sample each bit at the end of the high phase
  task automatic read_word(output logic [17:0] w);
    if (chip_select_n) begin
      chip_select_n = 1'b0;
      cyc(4);
    end
    w[17] = serial_result_out;
    for (int i = 16; i >= 0; i--) begin
      shift_clk = 1'b0;
      cyc(4);
      shift_clk = 1'b1;
      cyc(4);
      w[i] = serial_result_out;
    end
    chip_select_n = 1'b1;
    cyc(4);
  endtask
  // after power-down: settle, then throw away two conversions
  task automatic resume_wait(input int n);
    cyc(n);
    repeat (2) begin // results of these are not trusted
      start_conv();
      cyc(60);
    end
    chip_select_n = 1'b1;
    cyc(4);
  endtask
endmodule // host_model
`default_nettype wire

// [dv/sar_adc_convert_and_serial_readout_bench.sv]
// self-checking bench of the converter control and serial readout
`timescale 1ns/100ps
`default_nettype none
`include "sar_conv_map.svh"
module sar_adc_convert_and_serial_readout_bench;
  // ----------------------------------------
  // shortened resume counts keep the run brief
  // ----------------------------------------
  localparam int UNTRIM = 20;
  localparam int INTREF = 50;
  logic clk_sys, resetn, internal_ref_used;
  logic convert_request, chip_select_n, frame_sync_in, shift_clk, powerdown_request;
  logic [17:0] conv_code;
  logic busy, serial_result_out, serial_out_en, nap_active, full_powerdown, resume_done;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  sar_conv_ctrl #(.UNTRIM_CYC(UNTRIM), .INTREF_CYC(INTREF)) uut (.clk_sys(clk_sys),
    .resetn(resetn), .convert_request(convert_request), .chip_select_n(chip_select_n),
    .frame_sync_in(frame_sync_in), .shift_clk(shift_clk),
    .powerdown_request(powerdown_request), .internal_ref_used(internal_ref_used),
    .conv_code(conv_code), .busy(busy), .serial_result_out(serial_result_out),
    .serial_out_en(serial_out_en), .nap_active(nap_active),
    .full_powerdown(full_powerdown), .resume_done(resume_done));
  host_model host (.clk_sys(clk_sys), .serial_result_out(serial_result_out),
    .convert_request(convert_request), .chip_select_n(chip_select_n),
    .frame_sync_in(frame_sync_in), .shift_clk(shift_clk),
    .powerdown_request(powerdown_request));
  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // a stuck handshake must still end in the report
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  // ----------------------------------------
  // shared checks
  // ----------------------------------------
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for busy to reach a level
  task automatic wait_busy(input logic lvl, input int lim, output int n);
    n = 0;
    while (busy !== lvl && n < lim) begin
      host.cyc(1);
      n++;
    end
  endtask
  task automatic results();
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // resume after reset release uses the untrimmed count only
  task automatic t_reset();
    chk(busy | full_powerdown | resume_done | serial_out_en, 1'b0);
    resetn = 1'b1;
    host.cyc(15);
    chk(resume_done, 1'b0);
    host.cyc(10);
    chk(resume_done, 1'b1);
  endtask
  // convert, reload at busy fall with frame sync high, read the word
  task automatic t_convert_read();
    int n;
    logic [17:0] w;
    conv_code = 18'h2A5C3;
    host.start_conv();
    wait_busy(1'b1, 6, n);
    chk(busy, 1'b1);
    wait_busy(1'b0, 60, n);
    chk(n >= 38 && n <= 42, 1'b1);
    host.cyc(2);
    chk(serial_out_en, 1'b1);
    chk(serial_result_out, 1'b1);
    chk(nap_active, 1'b0);
    host.read_word(w);
    chk(w, 18'h2A5C3);
    chk(nap_active, 1'b1);
  endtask
  // deselected pins must change nothing
  task automatic t_gating();
    logic s;
    s = serial_result_out;
    // the pins belong to the host model, so drive them through it
    host.convert_request = 1'b1;
    host.cyc(4);
    host.convert_request = 1'b0;
    host.frame_sync_in = 1'b0;
    host.shift_clk = 1'b0;
    host.cyc(20);
    chk(busy, 1'b0);
    host.frame_sync_in = 1'b1;
    host.shift_clk = 1'b1;
    host.cyc(10);
    chk(serial_out_en, 1'b0);
    chk(serial_result_out, s);
  endtask
  // abort mid-conversion: busy drops at once, fixed code is read
  task automatic t_abort();
    int n;
    logic [17:0] w;
    conv_code = 18'h15555;
    host.start_conv();
    wait_busy(1'b1, 6, n);
    host.cyc(10);
    host.abort_conv();
    wait_busy(1'b0, 6, n);
    chk(busy, 1'b0);
    host.chip_select_n = 1'b1;
    host.cyc(4);
    host.read_word(w);
    chk(w, `ABORT_CODE);
  endtask
  // power-down entry time, then the longer resume with the internal reference
  task automatic t_powerdown();
    host.powerdown_request = 1'b1;
    host.cyc(390);
    chk(busy | resume_done | serial_out_en, 1'b0);
    chk(full_powerdown, 1'b0);
    host.cyc(20);
    chk(full_powerdown, 1'b1);
    internal_ref_used = 1'b1;
    host.powerdown_request = 1'b0;
    host.cyc(60);
    chk(resume_done, 1'b0);
    host.cyc(20);
    chk(resume_done, 1'b1);
    host.resume_wait(0);
    chk(busy, 1'b0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    internal_ref_used = 1'b0;
    conv_code = 18'h00000;
    host.cyc(6);
    t_reset();
    t_convert_read();
    t_gating();
    t_abort();
    t_powerdown();
    results();
  end
endmodule // sar_adc_convert_and_serial_readout_bench
`default_nettype wire
